// ===== design/flash_prot_cfg.svh
// Sizes, fill value and geometry constants for the flash protection block
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

`define FBP_FLASH_BYTES 65536
`define FBP_ERASE_BYTES 1024
`define FBP_PROT_BYTES 2048
`define FBP_WORD_BYTES 4
`define FBP_ERASED_WORD 32'hffffffff
`define FBP_NO_DATA 32'h00000000

`endif

// ===== design/flash_prot_pkg.sv
// Types shared by the flash protection block and its region guard
package flash_prot_pkg;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_ERASE = 2'b10
  } op_e;

  typedef enum logic [1:0] {
    SRC_FETCH = 2'b00,
    SRC_DATA = 2'b01,
    SRC_DEBUG = 2'b10
  } src_e;

  // Code 2'b11 is not a defined setting and is treated as execute-only
  typedef enum logic [1:0] {
    PROT_NONE = 2'b00,
    PROT_RO = 2'b01,
    PROT_XO = 2'b10,
    PROT_RSVD = 2'b11
  } prot_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_ERASE = 2'b10,
    ST_RESP = 2'b11
  } state_e;

  typedef struct packed {
    op_e op;
    src_e src;
    logic [15:0] addr;
    logic [31:0] wdata;
  } req_s;

  typedef struct packed {
    logic write;
    logic [13:0] windex;
    logic [31:0] wdata;
  } arr_s;

endpackage : flash_prot_pkg

// ===== design/region_guard.sv
// Access decision for one protection region
`timescale 1ns/100ps

module region_guard (
  input wire flash_prot_pkg::prot_e prot,
  input wire flash_prot_pkg::op_e op,
  input wire flash_prot_pkg::src_e src,
  output logic deny,
  output logic is_ro,
  output logic is_xo
);

  wire is_read = (op == flash_prot_pkg::OP_READ);
  wire is_fetch = (src == flash_prot_pkg::SRC_FETCH);

  // Undefined setting falls to the strictest level
  assign is_ro = (prot == flash_prot_pkg::PROT_RO);
  assign is_xo = (prot == flash_prot_pkg::PROT_XO) ||
                 (prot == flash_prot_pkg::PROT_RSVD);

  // Modify refused on both levels; data reads refused on execute-only
  assign deny = (!is_read && (is_ro || is_xo))
              || (is_read && is_xo && !is_fetch);

endmodule : region_guard

// ===== design/flash_block_protection.sv
// Flash block access gate: protection check, erase sequencer, array port
//
// Contract
// - Flash array holds 64 KB, addressed as on-chip nonvolatile memory.
// - Erase works on 1-KB units, each erased without touching others.
// - Erase leaves every bit of the unit at one.
// - Protection is set per 2-KB pair of erase units, independently.
// - Each region is unprotected, read-only or execute-only.
// - Read-only regions refuse erase and program but allow reads.
// - Execute-only regions refuse erase and program.
// - Execute-only regions serve instruction fetch only, not data or debug.
`timescale 1ns/100ps
`include "flash_prot_cfg.svh"

module flash_block_protection #(
  parameter int FLASH_BYTES = `FBP_FLASH_BYTES,
  parameter int ERASE_BYTES = `FBP_ERASE_BYTES,
  parameter int PROT_BYTES = `FBP_PROT_BYTES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire flash_prot_pkg::prot_e [FLASH_BYTES/PROT_BYTES-1:0] region_prot,
  input wire logic req_valid,
  output logic req_ready,
  input wire flash_prot_pkg::req_s req,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [31:0] rsp_rdata,
  output logic arr_valid,
  output flash_prot_pkg::arr_s arr_req,
  input wire logic arr_ack,
  input wire logic [31:0] arr_rdata
);

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = $clog2(FLASH_BYTES);
  localparam int UNIT_LSB = $clog2(ERASE_BYTES);
  localparam int PROT_LSB = $clog2(PROT_BYTES);
  localparam int WORD_LSB = $clog2(`FBP_WORD_BYTES);
  localparam int CNT_W = UNIT_LSB - WORD_LSB;
  localparam int NREG = FLASH_BYTES / PROT_BYTES;
  localparam logic [CNT_W-1:0] CNT_LAST = '1;

  // The package fixes a 16-bit byte address, so only 64 KB fits
  if (ADDR_W != 16 || (1 << ADDR_W) != FLASH_BYTES)
  begin : bad_flash_size
    $error("flash size must be 64 KB");
  end
  if (PROT_BYTES != 2 * ERASE_BYTES)
  begin : bad_prot_size
    $error("protection region must pair two erase units");
  end
  if ((1 << UNIT_LSB) != ERASE_BYTES || ERASE_BYTES < 8)
  begin : bad_erase_size
    $error("erase unit must be a power of two of at least 8 bytes");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  flash_prot_pkg::state_e state_q, state_d;
  flash_prot_pkg::req_s req_q;
  logic [CNT_W-1:0] cnt_q;
  logic rsp_err_q;
  logic [31:0] rsp_rdata_q;

  // ---------------------------------------------------------------
  // Protection lookup on the incoming request
  // ---------------------------------------------------------------
  wire [ADDR_W-PROT_LSB-1:0] reg_idx = req.addr[ADDR_W-1:PROT_LSB];
  wire flash_prot_pkg::prot_e cur_prot = region_prot[reg_idx];
  logic deny;
  logic hit_ro;
  logic hit_xo;

  region_guard u_guard (
    .prot(cur_prot),
    .op(req.op),
    .src(req.src),
    .deny(deny),
    .is_ro(hit_ro),
    .is_xo(hit_xo)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire in_idle = (state_q == flash_prot_pkg::ST_IDLE);
  wire in_access = (state_q == flash_prot_pkg::ST_ACCESS);
  wire in_erase = (state_q == flash_prot_pkg::ST_ERASE);
  wire in_resp = (state_q == flash_prot_pkg::ST_RESP);
  wire take = ce && in_idle && req_valid;
  wire acked = ce && arr_ack && (in_access || in_erase);
  wire erase_done = in_erase && acked && (cnt_q == CNT_LAST);
  wire is_erase = (req.op == flash_prot_pkg::OP_ERASE);
  wire q_read = (req_q.op == flash_prot_pkg::OP_READ);
  wire q_write = (req_q.op == flash_prot_pkg::OP_PROGRAM);

  assign req_ready = ce && in_idle;
  assign rsp_valid = ce && in_resp;
  assign rsp_err = rsp_err_q;
  assign rsp_rdata = rsp_rdata_q;

  // A denied request never reaches the array port
  assign arr_valid = in_access || in_erase;

  // Erase walks every word of the addressed unit only
  wire [13:0] erase_idx = {req_q.addr[ADDR_W-1:UNIT_LSB], cnt_q};
  wire [13:0] word_idx = req_q.addr[ADDR_W-1:WORD_LSB];

  assign arr_req.write = in_erase || q_write;
  assign arr_req.windex = in_erase ? erase_idx : word_idx;
  // Erase is done as all-ones fill so no bit of the unit is left low
  assign arr_req.wdata = in_erase ? `FBP_ERASED_WORD : req_q.wdata;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      flash_prot_pkg::ST_IDLE:
        if (take)
        begin
          if (deny)
            state_d = flash_prot_pkg::ST_RESP;
          else if (is_erase)
            state_d = flash_prot_pkg::ST_ERASE;
          else
            state_d = flash_prot_pkg::ST_ACCESS;
        end
      flash_prot_pkg::ST_ACCESS:
        if (acked)
          state_d = flash_prot_pkg::ST_RESP;
      flash_prot_pkg::ST_ERASE:
        if (erase_done)
          state_d = flash_prot_pkg::ST_RESP;
      flash_prot_pkg::ST_RESP:
        if (ce)
          state_d = flash_prot_pkg::ST_IDLE;
      default:
        state_d = flash_prot_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_q <= flash_prot_pkg::ST_IDLE;
    else if (ce)
      state_q <= state_d;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      req_q <= '0;
    else if (take)
      req_q <= req;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || take)
      cnt_q <= '0;
    else if (in_erase && acked)
      cnt_q <= cnt_q + 1'b1;
  end

  // Error answer carries no array data
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rsp_err_q <= 1'b0;
      rsp_rdata_q <= `FBP_NO_DATA;
    end
    else if (take)
    begin
      rsp_err_q <= deny;
      rsp_rdata_q <= `FBP_NO_DATA;
    end
    else if (in_access && acked && q_read)
      rsp_rdata_q <= arr_rdata;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ro_modify_refused_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && hit_ro && req.op != flash_prot_pkg::OP_READ
    |=> state_q == flash_prot_pkg::ST_RESP && rsp_err_q)
    else $error("read-only region accepted a modify");

  ro_read_served_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && hit_ro && req.op == flash_prot_pkg::OP_READ
    |=> state_q == flash_prot_pkg::ST_ACCESS && !rsp_err_q)
    else $error("read-only region refused a read");

  xo_modify_refused_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && hit_xo && req.op != flash_prot_pkg::OP_READ
    |=> state_q == flash_prot_pkg::ST_RESP && rsp_err_q)
    else $error("execute-only region accepted a modify");

  xo_data_denied_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && hit_xo && req.op == flash_prot_pkg::OP_READ &&
    req.src != flash_prot_pkg::SRC_FETCH
    |=> rsp_err_q && !arr_valid)
    else $error("execute-only region served a data read");

  xo_fetch_served_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && hit_xo && req.op == flash_prot_pkg::OP_READ &&
    req.src == flash_prot_pkg::SRC_FETCH
    |=> arr_valid && !arr_req.write)
    else $error("execute-only region refused a fetch");

  err_no_data_a: assert property (@(posedge ref_clk) disable iff (reset)
    rsp_valid && rsp_err_q |-> rsp_rdata_q == `FBP_NO_DATA)
    else $error("error answer carried data");

  erase_all_ones_a: assert property (@(posedge ref_clk) disable iff (reset)
    arr_valid && in_erase
    |-> arr_req.write && arr_req.wdata == `FBP_ERASED_WORD)
    else $error("erase wrote a word other than all ones");

  erase_in_unit_a: assert property (@(posedge ref_clk) disable iff (reset)
    in_erase |-> arr_req.windex[13:CNT_W] ==
      req_q.addr[ADDR_W-1:UNIT_LSB])
    else $error("erase left its unit");

  erase_length_a: assert property (@(posedge ref_clk) disable iff (reset)
    in_erase && acked && cnt_q == CNT_LAST
    |=> state_q == flash_prot_pkg::ST_RESP && cnt_q == '0)
    else $error("erase did not end after the last word");

  erase_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && !deny && is_erase
    |=> in_erase && cnt_q == '0 && !rsp_err_q)
    else $error("erase did not start from the first word");

  denied_cov_c: cover property (@(posedge ref_clk) disable iff (reset)
    take && deny ##1 rsp_valid);
  erase_cov_c: cover property (@(posedge ref_clk) disable iff (reset)
    erase_done ##1 rsp_valid && !rsp_err_q);
  fetch_xo_cov_c: cover property (@(posedge ref_clk) disable iff (reset)
    take && hit_xo && req.src == flash_prot_pkg::SRC_FETCH);

endmodule : flash_block_protection

// ===== tb/flash_array_model.sv
// Behavioural flash array answering the gate's word requests
`timescale 1ns/100ps

module flash_array_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] lat,
  input wire logic arr_valid,
  input wire flash_prot_pkg::arr_s arr_req,
  output logic arr_ack,
  output logic [31:0] arr_rdata
);
  // One 32-bit word per index across the whole array
  logic [31:0] mem [16384];
  logic [3:0] wait_q;

  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = {16'h5a5a, 2'b00, i[13:0]};
  end

  // Read data is valid only in the ack cycle; it toggles otherwise so
  // stale data is never mistaken for a fresh answer
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      arr_ack <= 1'b0;
      arr_rdata <= 32'h0;
      wait_q <= 4'h0;
    end
    else
    begin
      arr_ack <= 1'b0;
      arr_rdata <= ~arr_rdata;
      if (arr_valid && !arr_ack)
      begin
        if (wait_q < lat)
          wait_q <= wait_q + 4'h1;
        else
        begin
          wait_q <= 4'h0;
          arr_ack <= 1'b1;
          arr_rdata <= mem[arr_req.windex];
          if (arr_req.write)
            mem[arr_req.windex] <= arr_req.wdata;
        end
      end
    end
  end
endmodule : flash_array_model

// ===== tb/flash_block_protection_tb.sv
// Self-checking bench for the flash protection gate
`timescale 1ns/100ps

module flash_block_protection_tb;
  logic ref_clk, reset, ce, req_valid, req_ready, rsp_valid, rsp_err;
  logic arr_valid, arr_ack, got_err;
  logic [31:0] rsp_rdata, arr_rdata, got_data;
  logic [3:0] lat;
  flash_prot_pkg::prot_e [31:0] region_prot;
  flash_prot_pkg::req_s req;
  flash_prot_pkg::arr_s arr_req;
  int failures, check_count;

  flash_block_protection dut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .region_prot(region_prot), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .arr_valid(arr_valid),
    .arr_req(arr_req), .arr_ack(arr_ack), .arr_rdata(arr_rdata));
  flash_array_model array (.ref_clk(ref_clk), .reset(reset), .lat(lat),
    .arr_valid(arr_valid), .arr_req(arr_req), .arr_ack(arr_ack),
    .arr_rdata(arr_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------
  // Shared tasks
  // ----------------
  function automatic logic [31:0] pat(input logic [15:0] a);
    return {16'h5a5a, 2'b00, a[15:2]};
  endfunction : pat

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Bounded wait; a hang ends the run with a mismatch
  task automatic wait_high(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 4000)
      begin
        failures++;
        $display("unexpected wait: expected high, seen timeout");
        summarize();
      end
    end
  endtask : wait_high

  task automatic xfer(input flash_prot_pkg::op_e op,
    input flash_prot_pkg::src_e src, input logic [15:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b1;
    req = '{op: op, src: src, addr: a, wdata: d};
    wait_high(req_ready);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    wait_high(rsp_valid);
    got_err = rsp_err;
    got_data = rsp_rdata;
  endtask : xfer

  task automatic read_expect(input logic [15:0] a, input logic [31:0] e);
    xfer(flash_prot_pkg::OP_READ, flash_prot_pkg::SRC_FETCH, a, 32'h0);
    check("read data", e, got_data);
  endtask : read_expect

  // One-cycle reset in mid-run, released off the clock edge
  task automatic pulse_reset();
    @(posedge ref_clk);
    #1;
    reset = 1'b1;
    @(posedge ref_clk);
    #1;
    reset = 1'b0;
  endtask : pulse_reset

  // ----------------
  // Scenarios
  // ----------------
  task automatic test_rw();
    lat = 4'h0;
    read_expect(16'h0004, pat(16'h0004));
    xfer(flash_prot_pkg::OP_PROGRAM, flash_prot_pkg::SRC_DATA, 16'hfffc,
      32'h1234abcd);
    check("program error", 32'h0, {31'h0, got_err});
    lat = 4'h3;
    read_expect(16'hfffc, 32'h1234abcd);
    $display("test read and program done");
  endtask : test_rw

  task automatic test_erase();
    lat = 4'h1;
    xfer(flash_prot_pkg::OP_ERASE, flash_prot_pkg::SRC_DEBUG, 16'h0a10,
      32'h0);
    check("erase error", 32'h0, {31'h0, got_err});
    read_expect(16'h0800, 32'hffffffff);
    read_expect(16'h0bfc, 32'hffffffff);
    read_expect(16'h0c00, pat(16'h0c00));
    read_expect(16'h07fc, pat(16'h07fc));
    $display("test erase done");
  endtask : test_erase

  // Every operation and source against each protected setting of one
  // region, while its neighbour stays open
  task automatic test_prot();
    logic deny;
    logic xo;
    for (int p = 1; p < 4; p++)
    begin
      region_prot[5] = flash_prot_pkg::prot_e'(p);
      xo = (p != 1);
      for (int o = 0; o < 3; o++)
        for (int s = 0; s < 3; s++)
        begin
          deny = (o != 0) || (xo && s != 0);
          xfer(flash_prot_pkg::op_e'(o), flash_prot_pkg::src_e'(s),
            16'h2a04, 32'h0);
          check("refusal", {31'h0, deny}, {31'h0, got_err});
          check("data", deny ? 32'h0 : pat(16'h2a04), got_data);
        end
      read_expect(16'h2a04, pat(16'h2a04));
      xfer(flash_prot_pkg::OP_PROGRAM, flash_prot_pkg::SRC_DATA, 16'h27fc,
        32'h00c0ffe0 + p);
      check("open region error", 32'h0, {31'h0, got_err});
      read_expect(16'h27fc, 32'h00c0ffe0 + p);
    end
    region_prot[5] = flash_prot_pkg::PROT_NONE;
    $display("test protection done");
  endtask : test_prot

  // Clock enable low freezes the gate before a take and in mid-access;
  // the array keeps acking meanwhile and those acks must be ignored
  task automatic test_freeze();
    lat = 4'h0;
    @(posedge ref_clk);
    #1;
    ce = 1'b0;
    req_valid = 1'b1;
    req = '{op: flash_prot_pkg::OP_READ, src: flash_prot_pkg::SRC_DATA,
      addr: 16'h0104, wdata: 32'h0};
    repeat (3)
    begin
      @(posedge ref_clk);
      #1;
      check("ready while frozen", 32'h0, {31'h0, req_ready});
      check("array while frozen", 32'h0, {31'h0, arr_valid});
    end
    ce = 1'b1;
    wait_high(req_ready);
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    ce = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      #1;
      check("answer while frozen", 32'h0, {31'h0, rsp_valid});
      check("access held", 32'h1, {31'h0, arr_valid});
    end
    ce = 1'b1;
    wait_high(rsp_valid);
    check("frozen read data", pat(16'h0104), rsp_rdata);
    $display("test clock enable done");
  endtask : test_freeze

  // Reset in mid-run clears the answer registers, and the gate takes a
  // request again straight after release
  task automatic test_reset();
    region_prot[3] = flash_prot_pkg::PROT_RO;
    xfer(flash_prot_pkg::OP_ERASE, flash_prot_pkg::SRC_DATA, 16'h1800,
      32'h0);
    check("refused erase", 32'h1, {31'h0, got_err});
    pulse_reset();
    check("error after reset", 32'h0, {31'h0, rsp_err});
    check("ready after reset", 32'h1, {31'h0, req_ready});
    check("answer after reset", 32'h0, {31'h0, rsp_valid});
    check("array after reset", 32'h0, {31'h0, arr_valid});
    read_expect(16'h1804, pat(16'h1804));
    pulse_reset();
    check("data after reset", 32'h0, rsp_rdata);
    region_prot[3] = flash_prot_pkg::PROT_NONE;
    $display("test reset done");
  endtask : test_reset

  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lat = 4'h0;
    region_prot = '0;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    test_rw();
    test_erase();
    test_prot();
    test_freeze();
    test_reset();
    summarize();
  end
endmodule : flash_block_protection_tb
